/* src/capture_compare_unit.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - 16-bit timer reloads from reload value
// - prescaler divides by 1 to 1024
// - four pwm outputs, polarity, sym/asym
// - seven flags share one interrupt
// - 16-bit writes via high-byte shadow
// - basic mode pclk, pwm mode multiplier
// - multiplier output times 32 reference
// - 4-bit divider feeds multiplier reference
// - 10-bit prescaler reloads at overflow
// - direction bit reverses count at once
// - timer readable and writable while running
// - reload sets overflow flag
// - optional 8-bit counter mode
// - compare acts only when channel enabled
// - match sets compare match flag
// - capture always on, copies timer
// - capture edge rising or falling
// - filter needs four equal samples
// - event counter delays capture
module capture_compare_unit #(
    parameter int NUM_CMP = 4,
    parameter int NUM_CAP = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire capcomp_pkg::apb_req_t apb_req,
    output capcomp_pkg::apb_rsp_t apb_rsp,
    // capture pins
    input wire logic [NUM_CAP-1:0] capture_in,
    // compare pins
    output logic [NUM_CMP-1:0] compare_out,
    output logic [NUM_CMP-1:0] compare_oe,
    // shared interrupt
    output logic irq
);

    localparam int NFLAG = 1 + NUM_CAP + NUM_CMP;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [9:0] presc_rld;
        logic [9:0] presc_cnt;
        logic [15:0] timer;
        logic [15:0] reload;
        logic [NUM_CMP-1:0][15:0] cmp;
        logic [NUM_CAP-1:0][15:0] cap;
        logic [15:0] outcfg;
        logic [15:0] capcfg;
        logic [NFLAG-1:0] flags;
        logic [NFLAG-1:0] ien;
        logic [7:0] wshadow;
        logic sym_down;
        logic [NUM_CMP-1:0] toggle;
        logic [NUM_CMP-1:0] out;
        logic [NUM_CAP-1:0] s1;
        logic [NUM_CAP-1:0] s2;
        logic [NUM_CAP-1:0] s3;
        logic [NUM_CAP-1:0] lvl;
        logic [NUM_CAP-1:0][1:0] fcnt;
        logic [NUM_CAP-1:0][3:0] evcnt;
        capcomp_pkg::pll_state_t pll_st;
        logic [3:0] pll_div_cnt;
        logic [5:0] pll_lock_cnt;
        logic [31:0] prdata;
        logic err;
    } state_t;

    state_t r;
    state_t n;

    // shadowed 16-bit write: a high-byte-only write parks in the shadow,
    // a low-byte write commits both bytes at once
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [7:0] hi,
                                         input logic [31:0] d, input logic [3:0] s);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v = {(s[1] ? d[15:8] : hi), d[7:0]};
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic setup;
        logic wr;
        logic unit_tick;
        logic ptick;
        logic ovf;
        logic down;
        logic sw_timer;
        logic [15:0] top;
        logic [15:0] cur;
        logic [15:0] nt;
        logic [7:0] a;
        logic [31:0] rd;
        logic hit;
        logic sig;
        logic edge_ok;
        logic [NFLAG-1:0] set;
        logic [NFLAG-1:0] clr;
        logic [NUM_CMP-1:0] lvlp;
        setup = 1'b0;
        wr = 1'b0;
        unit_tick = 1'b0;
        ptick = 1'b0;
        ovf = 1'b0;
        down = 1'b0;
        sw_timer = 1'b0;
        top = 16'h0000;
        cur = r.timer;
        nt = r.timer;
        a = apb_req.paddr;
        rd = 32'h0000_0000;
        hit = 1'b1;
        sig = 1'b0;
        edge_ok = 1'b0;
        set = '0;
        clr = '0;
        lvlp = '0;
        n = r;

        // reference divider and multiplier lock; the multiplied clock is
        // faster than pclk, so once locked the unit ticks every pclk
        if (r.pll_div_cnt == r.ctrl[capcomp_pkg::CTRL_PLLDIV +: 4]) begin
            n.pll_div_cnt = 4'h0;
        end else begin
            n.pll_div_cnt = r.pll_div_cnt + 4'h1;
        end
        case (r.pll_st)
            capcomp_pkg::PLL_OFF: begin
                n.pll_lock_cnt = 6'h00;
                if (r.ctrl[capcomp_pkg::CTRL_PWM]) begin
                    n.pll_st = capcomp_pkg::PLL_LOCKING;
                end
            end
            capcomp_pkg::PLL_LOCKING: begin
                if (!r.ctrl[capcomp_pkg::CTRL_PWM]) begin
                    n.pll_st = capcomp_pkg::PLL_OFF;
                end else if (r.pll_div_cnt == 4'h0) begin
                    n.pll_lock_cnt = r.pll_lock_cnt + 6'h01;
                    if (r.pll_lock_cnt == capcomp_pkg::PLL_LOCK_REF_CYCLES - 6'h01) begin
                        n.pll_st = capcomp_pkg::PLL_LOCKED;
                    end
                end
            end
            capcomp_pkg::PLL_LOCKED: begin
                if (!r.ctrl[capcomp_pkg::CTRL_PWM]) begin
                    n.pll_st = capcomp_pkg::PLL_OFF;
                end
            end
            default: begin
                n.pll_st = capcomp_pkg::PLL_OFF;
            end
        endcase

        // clock source select: pclk in basic mode, multiplier in pwm modes
        unit_tick = r.ctrl[capcomp_pkg::CTRL_PWM] ?
                    (r.pll_st == capcomp_pkg::PLL_LOCKED) : 1'b1;

        // free-running prescaler, ratio is 1024 minus reload value
        if (unit_tick) begin
            if (r.presc_cnt == capcomp_pkg::PRESC_TOP) begin
                n.presc_cnt = r.presc_rld;
                ptick = 1'b1;
            end else begin
                n.presc_cnt = r.presc_cnt + 10'h001;
            end
        end
        ptick = ptick & r.ctrl[capcomp_pkg::CTRL_RUN];

        // timer step; direction bit is read every tick so a change
        // reverses the sequence at the next step
        top = r.ctrl[capcomp_pkg::CTRL_MODE8] ? {8'h00, r.reload[7:0]} : r.reload;
        down = r.ctrl[capcomp_pkg::CTRL_DOWN];
        if (r.ctrl[capcomp_pkg::CTRL_PWM] && r.ctrl[capcomp_pkg::CTRL_SYM]) begin
            if (!r.sym_down) begin
                if (cur >= top) begin
                    n.sym_down = 1'b1;
                    nt = cur - 16'h0001;
                end else begin
                    nt = cur + 16'h0001;
                end
            end else if (cur == 16'h0000) begin
                n.sym_down = 1'b0;
                nt = 16'h0001;
                ovf = 1'b1;
            end else begin
                nt = cur - 16'h0001;
            end
        end else if (!down) begin
            if (cur >= top) begin
                nt = 16'h0000;
                ovf = 1'b1;
            end else begin
                nt = cur + 16'h0001;
            end
        end else if (cur == 16'h0000) begin
            nt = top;
            ovf = 1'b1;
        end else begin
            nt = cur - 16'h0001;
        end
        if (r.ctrl[capcomp_pkg::CTRL_MODE8]) begin
            nt = {8'h00, nt[7:0]};
        end
        if (ptick) begin
            n.timer = nt;
            set[capcomp_pkg::FLAG_OVF] = ovf;
        end

        // compare channels
        for (int i = 0; i < NUM_CMP; i++) begin
            if (ptick && r.outcfg[capcomp_pkg::OUTCFG_EN + i] && cur == r.cmp[i]) begin
                set[capcomp_pkg::FLAG_CMP + i] = 1'b1;
                n.toggle[i] = ~r.toggle[i];
            end
            // pwm level is high while timer is below compare; in symmetric
            // mode the triangle count centres the pulse
            lvlp[i] = r.ctrl[capcomp_pkg::CTRL_PWM] ? (r.timer < r.cmp[i]) : r.toggle[i];
            n.out[i] = r.outcfg[capcomp_pkg::OUTCFG_EN + i] &
                       (lvlp[i] ^ r.outcfg[capcomp_pkg::OUTCFG_POL + i]);
        end

        // capture channels: three-stage sync, optional filter, event count
        n.s1 = capture_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int c = 0; c < NUM_CAP; c++) begin
            sig = (r.s2[c] == r.s3[c]) ? r.s3[c] : r.lvl[c];
            edge_ok = 1'b0;
            if (r.capcfg[capcomp_pkg::CAPCFG_FILT + c]) begin
                if (sig != r.lvl[c]) begin
                    n.fcnt[c] = r.fcnt[c] + 2'h1;
                    if (r.fcnt[c] == capcomp_pkg::FILT_SAMPLES_M1) begin
                        n.lvl[c] = sig;
                        n.fcnt[c] = 2'h0;
                        edge_ok = 1'b1;
                    end
                end else begin
                    n.fcnt[c] = 2'h0;
                end
            end else begin
                n.fcnt[c] = 2'h0;
                n.lvl[c] = sig;
                edge_ok = (sig != r.lvl[c]);
            end
            if (edge_ok && (sig == r.capcfg[capcomp_pkg::CAPCFG_RISE + c])) begin
                if (r.evcnt[c] == r.capcfg[capcomp_pkg::CAPCFG_EVT + 4*c +: 4]) begin
                    n.evcnt[c] = 4'h0;
                    n.cap[c] = r.timer;
                    set[capcomp_pkg::FLAG_CAP + c] = 1'b1;
                end else begin
                    n.evcnt[c] = r.evcnt[c] + 4'h1;
                end
            end
        end

        // apb: read data latched in setup, writes land in the access cycle
        setup = apb_req.psel & ~apb_req.penable;
        wr = apb_req.psel & apb_req.penable & apb_req.pwrite & ~r.err;
        case (a)
            capcomp_pkg::OFF_CTRL: rd = {16'h0000, r.ctrl};
            capcomp_pkg::OFF_PRESC: rd = {22'h000000, r.presc_rld};
            capcomp_pkg::OFF_TIMER: rd = {16'h0000, r.timer};
            capcomp_pkg::OFF_RELOAD: rd = {16'h0000, r.reload};
            capcomp_pkg::OFF_OUTCFG: rd = {16'h0000, r.outcfg};
            capcomp_pkg::OFF_CAPCFG: rd = {16'h0000, r.capcfg};
            capcomp_pkg::OFF_FLAGS: rd = {{(32-NFLAG){1'b0}}, r.flags};
            capcomp_pkg::OFF_IEN: rd = {{(32-NFLAG){1'b0}}, r.ien};
            capcomp_pkg::OFF_STATUS: rd = {29'h0000000, r.pll_st};
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < NUM_CMP; i++) begin
            if (a == capcomp_pkg::OFF_CMP0 + 8'(4*i)) begin
                rd = {16'h0000, r.cmp[i]};
                hit = 1'b1;
            end
        end
        for (int c = 0; c < NUM_CAP; c++) begin
            if (a == capcomp_pkg::OFF_CAP0 + 8'(4*c)) begin
                rd = {16'h0000, r.cap[c]};
                hit = 1'b1;
            end
        end
        if (setup) begin
            n.prdata = hit ? rd : 32'h0000_0000;
            n.err = ~hit;
        end
        if (wr) begin
            if (apb_req.pstrb[1]) begin
                n.wshadow = apb_req.pwdata[15:8];
            end
            case (a)
                capcomp_pkg::OFF_CTRL: n.ctrl = wr16(r.ctrl, r.wshadow,
                                                     apb_req.pwdata, apb_req.pstrb);
                capcomp_pkg::OFF_PRESC: begin
                    if (apb_req.pstrb[0]) begin
                        n.presc_rld = {(apb_req.pstrb[1] ? apb_req.pwdata[9:8] :
                                        r.wshadow[1:0]), apb_req.pwdata[7:0]};
                    end
                end
                capcomp_pkg::OFF_TIMER: begin
                    n.timer = wr16(r.timer, r.wshadow, apb_req.pwdata, apb_req.pstrb);
                    sw_timer = apb_req.pstrb[0];
                end
                capcomp_pkg::OFF_RELOAD: n.reload = wr16(r.reload, r.wshadow,
                                                         apb_req.pwdata, apb_req.pstrb);
                capcomp_pkg::OFF_OUTCFG: n.outcfg = wr16(r.outcfg, r.wshadow,
                                                         apb_req.pwdata, apb_req.pstrb);
                capcomp_pkg::OFF_CAPCFG: n.capcfg = wr16(r.capcfg, r.wshadow,
                                                         apb_req.pwdata, apb_req.pstrb);
                capcomp_pkg::OFF_FLAGS: begin
                    if (apb_req.pstrb[0]) begin
                        clr = apb_req.pwdata[NFLAG-1:0];
                    end
                end
                capcomp_pkg::OFF_IEN: begin
                    if (apb_req.pstrb[0]) begin
                        n.ien = apb_req.pwdata[NFLAG-1:0];
                    end
                end
                default: begin
                end
            endcase
            for (int i = 0; i < NUM_CMP; i++) begin
                if (a == capcomp_pkg::OFF_CMP0 + 8'(4*i)) begin
                    n.cmp[i] = wr16(r.cmp[i], r.wshadow, apb_req.pwdata, apb_req.pstrb);
                end
            end
        end
        if (!sw_timer && ptick) begin
            n.timer = nt;
        end
        // a software write to the timer beats the count of that cycle
        if (sw_timer) begin
            n.timer = wr16(r.timer, r.wshadow, apb_req.pwdata, apb_req.pstrb);
        end

        // a disabled channel goes quiet in the very cycle its pin is released
        n.out = n.out & n.outcfg[capcomp_pkg::OUTCFG_EN +: NUM_CMP];

        // sticky flags; a hardware set in the clear cycle survives
        n.flags = (r.flags & ~clr) | set;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.ctrl <= capcomp_pkg::RST_CTRL;
            r.presc_rld <= capcomp_pkg::RST_PRESC;
            r.presc_cnt <= capcomp_pkg::RST_PRESC;
            r.reload <= capcomp_pkg::RST_RELOAD;
            r.cmp <= {NUM_CMP{capcomp_pkg::RST_CMP}};
            r.outcfg <= capcomp_pkg::RST_OUTCFG;
            r.capcfg <= capcomp_pkg::RST_CAPCFG;
            r.pll_st <= capcomp_pkg::PLL_OFF;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states: data was latched in the setup cycle
    assign apb_rsp = '{prdata: r.prdata, pready: 1'b1,
                       pslverr: r.err & apb_req.psel & apb_req.penable};
    assign compare_out = r.out;
    // pin driven only while the channel is enabled
    assign compare_oe = r.outcfg[capcomp_pkg::OUTCFG_EN +: NUM_CMP];
    assign irq = |(r.flags & r.ien);

endmodule

`default_nettype wire

/* inc/capcomp_pkg.sv */
package capcomp_pkg;

    // register byte offsets on the apb window
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRESC = 8'h04;
    localparam logic [7:0] OFF_TIMER = 8'h08;
    localparam logic [7:0] OFF_RELOAD = 8'h0c;
    localparam logic [7:0] OFF_CMP0 = 8'h10;
    localparam logic [7:0] OFF_CAP0 = 8'h20;
    localparam logic [7:0] OFF_OUTCFG = 8'h28;
    localparam logic [7:0] OFF_CAPCFG = 8'h2c;
    localparam logic [7:0] OFF_FLAGS = 8'h30;
    localparam logic [7:0] OFF_IEN = 8'h34;
    localparam logic [7:0] OFF_STATUS = 8'h38;

    // field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_DOWN = 1;
    localparam int CTRL_MODE8 = 2;
    localparam int CTRL_PWM = 3;
    localparam int CTRL_SYM = 4;
    localparam int CTRL_PLLDIV = 8;
    localparam int OUTCFG_EN = 0;
    localparam int OUTCFG_POL = 4;
    localparam int CAPCFG_RISE = 0;
    localparam int CAPCFG_FILT = 2;
    localparam int CAPCFG_EVT = 4;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CAP = 1;
    localparam int FLAG_CMP = 3;

    // reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [9:0] RST_PRESC = 10'h3ff;
    localparam logic [15:0] RST_RELOAD = 16'hffff;
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam logic [15:0] RST_OUTCFG = 16'h0000;
    localparam logic [15:0] RST_CAPCFG = 16'h0000;

    // timing counts
    localparam logic [9:0] PRESC_TOP = 10'h3ff;
    localparam logic [1:0] FILT_SAMPLES_M1 = 2'h3;
    localparam logic [5:0] PLL_LOCK_REF_CYCLES = 6'h20;

    // multiplier state, one-hot
    typedef enum logic [2:0] {
        PLL_OFF = 3'b001,
        PLL_LOCKING = 3'b010,
        PLL_LOCKED = 3'b100
    } pll_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

/* dv/capcomp_props.sv */
`timescale 1ns/10ps
`default_nettype none
module capcomp_props #(
    parameter int NUM_CMP = 4,
    parameter int NUM_CAP = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire capcomp_pkg::apb_req_t apb_req,
    input wire capcomp_pkg::apb_rsp_t apb_rsp,
    // pins and interrupt
    input wire logic [NUM_CAP-1:0] capture_in,
    input wire logic [NUM_CMP-1:0] compare_out,
    input wire logic [NUM_CMP-1:0] compare_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bad_addr;
    logic acc_wr;
    // words 00 to 38 all decode; anything past or misaligned is unmapped
    assign bad_addr = (apb_req.paddr > capcomp_pkg::OFF_STATUS) || (apb_req.paddr[1:0] != 2'b00);
    assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb[0];
    ////////////////////////////////////////////////////////////////
    // setup then access, split by decode result
    sequence s_bad_xfer;
        apb_req.psel && !apb_req.penable && bad_addr ##1 apb_req.psel && apb_req.penable;
    endsequence
    sequence s_good_xfer;
        apb_req.psel && !apb_req.penable && !bad_addr ##1 apb_req.psel && apb_req.penable;
    endsequence
    a_zero_wait: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
        else $error("pready low in an access phase");
    a_unmapped_error: assert property (s_bad_xfer |-> apb_rsp.pslverr && apb_rsp.prdata == '0)
        else $error("unmapped access without error or with data");
    a_mapped_no_error: assert property (s_good_xfer |-> !apb_rsp.pslverr)
        else $error("error on a decoded word");
    a_error_in_access: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
        else $error("pslverr outside an access phase");
    a_prdata_holds: assert property (!(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata))
        else $error("read data moved without a setup cycle");
    a_pin_quiet_off: assert property ((compare_out & ~compare_oe) == '0)
        else $error("compare pin active on a disabled channel");
    a_oe_needs_write: assert property ($changed(compare_oe) |->
            $past(acc_wr && apb_req.paddr == capcomp_pkg::OFF_OUTCFG))
        else $error("pin enable moved without an output config write");
    a_irq_masked_off: assert property (acc_wr && apb_req.paddr == capcomp_pkg::OFF_IEN
            && apb_req.pwdata[6:0] == 7'h00 |=> !irq)
        else $error("interrupt line high with all enables cleared");
endmodule
bind capture_compare_unit capcomp_props #(.NUM_CMP(NUM_CMP), .NUM_CAP(NUM_CAP)) props_u (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .capture_in(capture_in), .compare_out(compare_out), .compare_oe(compare_oe), .irq(irq));
`default_nettype wire

/* dv/capcomp_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module capcomp_pin_model (
    // clock
    input wire logic pclk,
    // pulse request from the bench
    input wire logic go,
    input wire logic ch,
    input wire logic [3:0] width,
    input wire logic clr,
    // unit pins
    input wire logic [3:0] cmp_out,
    input wire logic [3:0] cmp_oe,
    output logic [1:0] cap_pins,
    output logic [7:0] hi_cnt
);
    integer left = 0;
    logic sel = 1'b0;
    initial cap_pins = 2'b00;
    initial hi_cnt = 8'h00;
    // source pulse of whole pclk cycles from a low idle level
    always @(posedge pclk) begin
        if (go) begin
            sel <= ch;
            left <= width;
            cap_pins[ch] <= 1'b1;
        end else if (left > 1) begin
            left <= left - 1;
        end else if (left == 1) begin
            left <= 0;
            cap_pins[sel] <= 1'b0;
        end
    end
    // duty meter; an undriven pin floats, so it only counts while enabled
    always @(posedge pclk) begin
        if (clr)
            hi_cnt <= 8'h00;
        else if (cmp_oe[0] && cmp_out[0] && hi_cnt != 8'hff)
            hi_cnt <= hi_cnt + 8'h01;
    end
endmodule
`default_nettype wire

/* dv/capture_compare_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    capcomp_pkg::apb_req_t req = '0;
    capcomp_pkg::apb_rsp_t rsp;
    logic [1:0] pins;
    logic [3:0] cout;
    logic [3:0] coe;
    logic irq;
    logic go = 1'b0;
    logic gch = 1'b0;
    logic [3:0] gw = 4'h0;
    logic clr = 1'b0;
    logic [7:0] hi;
    logic [31:0] rd;
    logic er;
    integer n_fail = 0;
    integer checks_done = 0;
    integer seed = 32'h6bd6d912;
    integer t;
    integer i;
    integer vq[$];
    // reset image of the fifteen decoded words
    integer rst_img[0:14] = '{0, 'h3ff, 0, 'hffff, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1};

    always #5 pclk = ~pclk;

    capture_compare_unit dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .capture_in(pins), .compare_out(cout), .compare_oe(coe), .irq(irq));
    capcomp_pin_model pins_u (.pclk(pclk), .go(go), .ch(gch), .width(gw), .clr(clr),
        .cmp_out(cout), .cmp_oe(coe), .cap_pins(pins), .hi_cnt(hi));

    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // counts whose prescaler phase is unknown are checked in a window
    task automatic rng(input logic [31:0] got, input integer lo, input integer hb);
        ck({31'h0, (got >= lo) && (got <= hb)}, 32'h1);
    endtask
    // expected high cycles of a pwm pin over n unit clocks
    function automatic integer duty(input integer sym, input integer c, input integer n);
        duty = sym ? n * (2 * c - 1) / 18 : n * c / 10;
    endfunction
    // one transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        integer n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        ck(rd, exp);
    endtask
    task automatic pulse(input logic c, input logic [3:0] wd);
        @(posedge pclk);
        go <= 1'b1;
        gch <= c;
        gw <= wd;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // reset image, then an unmapped word written and read
        for (i = 0; i < 15; i++)
            rc(8'(i * 4), rst_img[i]);
        w(8'h3c, 32'hff);
        ck(er, 1'b1);
        rc(8'h3c, 32'h0);
        ck(er, 1'b1);
        // high byte parks in the shadow; the low byte commits the word
        for (i = 0; i < 5; i++) begin
            t = $random(seed) & 'hffff;
            apb(1'b1, 8'h0c + 8'(i * 4), 32'(t), 4'h2);
            rc(8'h0c + 8'(i * 4), (i == 0) ? 'hffff : 0);
            apb(1'b1, 8'h0c + 8'(i * 4), 32'(t) ^ 32'hff00, 4'h1);
            vq.push_back(t);
            rc(8'h0c + 8'(i * 4), vq.pop_front());
        end
        w(capcomp_pkg::OFF_CAP0, 32'h1234);
        rc(capcomp_pkg::OFF_CAP0, 32'h0);
        $display("register test done");
        // timer at /4, read while counting, turned round mid-run
        w(8'h0c, 32'h0fff);
        w(capcomp_pkg::OFF_TIMER, 32'h0100);
        rc(capcomp_pkg::OFF_TIMER, 32'h0100);
        w(capcomp_pkg::OFF_PRESC, 32'h3fc);
        w(capcomp_pkg::OFF_CTRL, 32'h1);
        repeat (80) @(posedge pclk);
        apb(1'b0, capcomp_pkg::OFF_TIMER, 32'h0, 4'h0);
        t = rd;
        rng(rd, 'h111, 'h117);
        w(capcomp_pkg::OFF_CTRL, 32'h3);
        repeat (80) @(posedge pclk);
        apb(1'b0, capcomp_pkg::OFF_TIMER, 32'h0, 4'h0);
        rng(rd, t - 23, t - 17);
        // /1, reload 9, channel 0 enabled and channel 1 not
        w(capcomp_pkg::OFF_CTRL, 32'h0);
        w(capcomp_pkg::OFF_PRESC, 32'h3ff);
        w(8'h0c, 32'h9);
        w(capcomp_pkg::OFF_CMP0, 32'h1);
        w(8'h14, 32'h1);
        w(capcomp_pkg::OFF_OUTCFG, 32'h1);
        w(capcomp_pkg::OFF_FLAGS, 32'h7f);
        ck(coe, 4'h1);
        w(capcomp_pkg::OFF_IEN, 32'h1);
        w(capcomp_pkg::OFF_CTRL, 32'h1);
        repeat (30) @(posedge pclk);
        w(capcomp_pkg::OFF_CTRL, 32'h0);
        ck(irq, 1'b1);
        rc(capcomp_pkg::OFF_FLAGS, 32'h9);
        apb(1'b0, capcomp_pkg::OFF_TIMER, 32'h0, 4'h0);
        rng(rd, 0, 9);
        // 8-bit mode wraps at the low byte of the reload word
        w(8'h0c, 32'h1234);
        w(capcomp_pkg::OFF_TIMER, 32'h30);
        w(capcomp_pkg::OFF_FLAGS, 32'h7f);
        w(capcomp_pkg::OFF_CTRL, 32'h5);
        repeat (40) @(posedge pclk);
        w(capcomp_pkg::OFF_CTRL, 32'h0);
        apb(1'b0, capcomp_pkg::OFF_TIMER, 32'h0, 4'h0);
        rng(rd, 0, 'h34);
        rc(capcomp_pkg::OFF_FLAGS, 32'h9);
        $display("timer test done");
        // multiplier must lock before pwm runs off it
        w(8'h0c, 32'h9);
        w(capcomp_pkg::OFF_CTRL, 32'h108);
        rc(capcomp_pkg::OFF_STATUS, 32'h2);
        t = 0;
        do begin
            apb(1'b0, capcomp_pkg::OFF_STATUS, 32'h0, 4'h0);
            t++;
        end while (rd !== 32'h4 && t < 40);
        ck(rd, 32'h4);
        // reference at pclk/2 needs about 64 cycles, some 22 status polls
        rng(t, 19, 25);
        // edge-aligned, inverted, then center-aligned duty
        for (i = 0; i < 3; i++) begin
            w(capcomp_pkg::OFF_OUTCFG, (i == 1) ? 32'h11 : 32'h1);
            w(capcomp_pkg::OFF_CTRL, (i == 2) ? 32'h19 : 32'h9);
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            repeat (200) @(posedge pclk);
            t = (i == 1) ? 200 - duty(0, 1, 200) : duty(i / 2, 1, 200);
            rng(hi, t - 4, t + 4);
        end
        $display("pwm test done");
        // capture: A rising with one edge skipped, B falling and filtered
        w(capcomp_pkg::OFF_CTRL, 32'h0);
        w(capcomp_pkg::OFF_OUTCFG, 32'h0);
        w(8'h0c, 32'hffff);
        w(capcomp_pkg::OFF_CAPCFG, 32'h19);
        w(capcomp_pkg::OFF_IEN, 32'h6);
        w(capcomp_pkg::OFF_FLAGS, 32'h7f);
        w(capcomp_pkg::OFF_CTRL, 32'h1);
        pulse(1'b0, 4'h8);
        repeat (20) @(posedge pclk);
        rc(capcomp_pkg::OFF_FLAGS, 32'h0);
        pulse(1'b0, 4'h8);
        repeat (20) @(posedge pclk);
        rc(capcomp_pkg::OFF_FLAGS, 32'h2);
        ck(irq, 1'b1);
        apb(1'b0, capcomp_pkg::OFF_CAP0, 32'h0, 4'h0);
        t = rd;
        apb(1'b0, capcomp_pkg::OFF_TIMER, 32'h0, 4'h0);
        rng(rd - 32'(t), 0, 60);
        pulse(1'b1, 4'h2);
        repeat (20) @(posedge pclk);
        rc(capcomp_pkg::OFF_FLAGS, 32'h2);
        pulse(1'b1, 4'hf);
        repeat (8) @(posedge pclk);
        rc(capcomp_pkg::OFF_FLAGS, 32'h2);
        repeat (20) @(posedge pclk);
        rc(capcomp_pkg::OFF_FLAGS, 32'h6);
        rc(capcomp_pkg::OFF_FLAGS, 32'h6);
        // flags still pending: masking every source must drop the line
        w(capcomp_pkg::OFF_IEN, 32'h0);
        @(posedge pclk);
        ck(irq, 1'b0);
        w(capcomp_pkg::OFF_IEN, 32'h6);
        w(capcomp_pkg::OFF_FLAGS, 32'h6);
        rc(capcomp_pkg::OFF_FLAGS, 32'h0);
        ck(irq, 1'b0);
        $display("capture test done");
        conclude();
    end
endmodule
`default_nettype wire
